// file: bdg_consts.svh
// Offsets, field positions, reset values and multipliers of the baud generator
`ifndef BDG_CONSTS_SVH
`define BDG_CONSTS_SVH

// Register offsets on the plain register port
`define BDG_OFS_BAUD_CONTROL   3'h0
`define BDG_OFS_RX_STATUS_CTRL 3'h1
`define BDG_OFS_DIVISOR_LOW    3'h2
`define BDG_OFS_DIVISOR_HIGH   3'h3
`define BDG_OFS_TX_STATUS_CTRL 3'h4

// Field positions in baud_control
`define BDG_BC_AUTOBAUD_OVF    7
`define BDG_BC_RX_IDLE         6
`define BDG_BC_CLK_POLARITY    4
`define BDG_BC_WIDE_DIVISOR    3
`define BDG_BC_WAKE_ENABLE     1
`define BDG_BC_AUTOBAUD_EN     0
// Writable bits of baud_control
`define BDG_BC_WR_MASK         8'h1b

// Field positions in transmit_status_control
`define BDG_TX_SYNC_MODE       4
`define BDG_TX_HIGH_SPEED      2
`define BDG_TX_SHIFT_EMPTY     1
// Writable bits of transmit_status_control
`define BDG_TX_WR_MASK         8'hfd

// Reset values
`define BDG_RST_BAUD_CONTROL   8'h00
`define BDG_RST_RX_STATUS_CTRL 8'h00
`define BDG_RST_TX_STATUS_CTRL 8'h00
`define BDG_RST_DIVISOR        8'h00

// Oscillator clocks per divisor step
`define BDG_MULT_64            7'h40
`define BDG_MULT_16            7'h10
`define BDG_MULT_4             7'h04

`endif

// file: bdg_pkg.sv
// Types shared by the baud generator and its users
package bdg_pkg;

    // One register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bdg_bus_req_s;

    // Settings handed to the transmitter and receiver
    typedef struct packed {
        logic       sync_mode;
        logic       high_speed;
        logic       wide_divisor;
        logic       clk_polarity;
        logic       serial_enable;
    } bdg_cfg_s;

    typedef logic [15:0] bdg_div_t;
    typedef logic [22:0] bdg_period_t;

endpackage

// file: bdg_baud_gen.sv
// Baud timer with its control and divisor registers
//
// Operation
// - One baud tick drives both asynchronous and synchronous serial use.
// - The timer counts as an 8-bit divider after reset, 16-bit when wide.
// - The timer runs freely with its period set by divisor low alone in 8-bit mode, by the divisor pair when wide.
// - Asynchronous clocks per step depend on high speed and wide select.
// - In synchronous mode the high speed select has no effect.
// - Writing either divisor byte clears the timer at once.
// - Async low osc/64(n+1) 8-bit, osc/16(n+1) 16-bit; sync 8 osc/4(n+1).
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bdg_consts.svh"

module bdg_baud_gen (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // Register port
    input  wire bdg_pkg::bdg_bus_req_s bus_req,
    output var  logic [7:0]        rd_data,
    // Status from the receiver and transmitter
    input  wire logic              receiver_idle_flag,
    input  wire logic              tx_shift_empty,
    // To the receiver and transmitter
    output var  logic              baud_tick,
    output var  bdg_pkg::bdg_cfg_s cfg
);
    import bdg_pkg::*;

    // Clocks per divisor step for a given mode
    function automatic logic [6:0] mult_f(
        input logic sync_m,
        input logic wide,
        input logic hs
    );
        logic [6:0] m;
        m = `BDG_MULT_4;
        if (!sync_m) begin
            if (wide) begin
                m = hs ? `BDG_MULT_4 : `BDG_MULT_16;
            end else begin
                m = hs ? `BDG_MULT_16 : `BDG_MULT_64;
            end
        end
        return m;
    endfunction

    // Register write decode
    function automatic logic hit_f(
        input bdg_bus_req_s r,
        input logic [2:0]   ofs
    );
        return r.wr && (r.addr == ofs);
    endfunction

    // ---------------- Registers ----------------
    logic [7:0] baud_control_q;
    logic [7:0] baud_control_d;
    logic [7:0] rx_ctrl_q;
    logic [7:0] rx_ctrl_d;
    logic [7:0] tx_ctrl_q;
    logic [7:0] tx_ctrl_d;
    logic [7:0] divisor_low_q;
    logic [7:0] divisor_low_d;
    logic [7:0] divisor_high_q;
    logic [7:0] divisor_high_d;
    logic       div_wr;
    logic       any_wr;

    always_comb begin
        baud_control_d = baud_control_q;
        rx_ctrl_d      = rx_ctrl_q;
        tx_ctrl_d      = tx_ctrl_q;
        divisor_low_d  = divisor_low_q;
        divisor_high_d = divisor_high_q;
        if (hit_f(bus_req, `BDG_OFS_BAUD_CONTROL)) begin
            baud_control_d = bus_req.wdata & `BDG_BC_WR_MASK;
        end
        if (hit_f(bus_req, `BDG_OFS_RX_STATUS_CTRL)) begin
            rx_ctrl_d = bus_req.wdata;
        end
        if (hit_f(bus_req, `BDG_OFS_TX_STATUS_CTRL)) begin
            tx_ctrl_d = bus_req.wdata & `BDG_TX_WR_MASK;
        end
        if (hit_f(bus_req, `BDG_OFS_DIVISOR_LOW)) begin
            divisor_low_d = bus_req.wdata;
        end
        if (hit_f(bus_req, `BDG_OFS_DIVISOR_HIGH)) begin
            divisor_high_d = bus_req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            baud_control_q <= `BDG_RST_BAUD_CONTROL;
            rx_ctrl_q      <= `BDG_RST_RX_STATUS_CTRL;
            tx_ctrl_q      <= `BDG_RST_TX_STATUS_CTRL;
            divisor_low_q  <= `BDG_RST_DIVISOR;
            divisor_high_q <= `BDG_RST_DIVISOR;
        end else begin
            baud_control_q <= baud_control_d;
            rx_ctrl_q      <= rx_ctrl_d;
            tx_ctrl_q      <= tx_ctrl_d;
            divisor_low_q  <= divisor_low_d;
            divisor_high_q <= divisor_high_d;
        end
    end

    assign div_wr = hit_f(bus_req, `BDG_OFS_DIVISOR_LOW)
                 || hit_f(bus_req, `BDG_OFS_DIVISOR_HIGH);
    assign any_wr = bus_req.wr;

    // ---------------- Mode decode ----------------
    logic       sync_m;
    logic       wide;
    logic       hs;
    logic [6:0] mult;
    bdg_div_t   div_n;

    assign sync_m = tx_ctrl_q[`BDG_TX_SYNC_MODE];
    assign wide   = baud_control_q[`BDG_BC_WIDE_DIVISOR];
    assign hs     = tx_ctrl_q[`BDG_TX_HIGH_SPEED];
    assign mult   = mult_f(sync_m, wide, hs);
    assign div_n  = wide ? {divisor_high_q, divisor_low_q}
                         : {8'h00, divisor_low_q};

    // ---------------- Baud timer ----------------
    logic [6:0] pre_q;
    logic [6:0] pre_d;
    bdg_div_t   cnt_q;
    bdg_div_t   cnt_d;
    logic       tick_q;
    logic       tick_d;
    logic       pre_end;
    logic       cnt_end;

    // Compare with >= so a mode change mid-count cannot overrun
    assign pre_end = (pre_q >= mult - 7'h01);
    assign cnt_end = (cnt_q >= div_n);

    always_comb begin
        pre_d  = pre_q + 7'h01;
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (div_wr) begin
            pre_d = 7'h00;
            cnt_d = 16'h0000;
        end else if (pre_end) begin
            pre_d = 7'h00;
            if (cnt_end) begin
                cnt_d  = 16'h0000;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pre_q  <= 7'h00;
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign baud_tick = tick_q;

    // ---------------- Read port and settings ----------------
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    bdg_cfg_s   cfg_q;
    bdg_cfg_s   cfg_d;

    always_comb begin
        rd_data_d = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `BDG_OFS_BAUD_CONTROL: begin
                    rd_data_d = baud_control_q;
                    rd_data_d[`BDG_BC_RX_IDLE] = receiver_idle_flag;
                end
                `BDG_OFS_RX_STATUS_CTRL: begin
                    rd_data_d = rx_ctrl_q;
                end
                `BDG_OFS_DIVISOR_LOW: begin
                    rd_data_d = divisor_low_q;
                end
                `BDG_OFS_DIVISOR_HIGH: begin
                    rd_data_d = divisor_high_q;
                end
                `BDG_OFS_TX_STATUS_CTRL: begin
                    rd_data_d = tx_ctrl_q;
                    rd_data_d[`BDG_TX_SHIFT_EMPTY] = tx_shift_empty;
                end
                default: begin
                    rd_data_d = 8'h00;
                end
            endcase
        end
        cfg_d.sync_mode     = tx_ctrl_d[`BDG_TX_SYNC_MODE];
        cfg_d.high_speed    = tx_ctrl_d[`BDG_TX_HIGH_SPEED];
        cfg_d.wide_divisor  = baud_control_d[`BDG_BC_WIDE_DIVISOR];
        cfg_d.clk_polarity  = baud_control_d[`BDG_BC_CLK_POLARITY];
        cfg_d.serial_enable = rx_ctrl_d[7];
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rd_data_q <= 8'h00;
            cfg_q     <= '0;
        end else begin
            rd_data_q <= rd_data_d;
            cfg_q     <= cfg_d;
        end
    end

    assign rd_data = rd_data_q;
    assign cfg     = cfg_q;

    // ---------------- Checking helpers ----------------
    bdg_period_t gap_q;
    bdg_period_t gap_d;
    logic        clean_q;
    logic        clean_d;
    bdg_period_t period;

    assign period = bdg_period_t'(mult * ({7'h00, div_n} + 23'h000001));

    always_comb begin
        gap_d   = tick_q ? 23'h000001 : gap_q + 23'h000001;
        clean_d = clean_q;
        if (tick_q) begin
            clean_d = 1'b1;
        end
        if (any_wr) begin
            clean_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            gap_q   <= 23'h000000;
            clean_q <= 1'b0;
        end else begin
            gap_q   <= gap_d;
            clean_q <= clean_d;
        end
    end

    // ---------------- Assertions ----------------
    property p_reset_narrow;
        @(posedge mclk) $rose(resetn) |-> !wide && div_n[15:8] == 8'h00;
    endproperty
    a_reset_narrow: assert property (p_reset_narrow)
        else $error("Timer not 8-bit after reset");

    property p_period;
        @(posedge mclk) disable iff (!resetn)
        tick_q && clean_q && !any_wr |-> gap_q == period;
    endproperty
    a_period: assert property (p_period)
        else $error("Baud period differs from multiplier times n+1");

    property p_clear_on_write;
        @(posedge mclk) disable iff (!resetn)
        div_wr |=> pre_q == 7'h00 && cnt_q == 16'h0000 && !tick_q;
    endproperty
    a_clear_on_write: assert property (p_clear_on_write)
        else $error("Divisor write did not clear timer");

    property p_sync_mult;
        @(posedge mclk) disable iff (!resetn)
        sync_m |-> mult == `BDG_MULT_4;
    endproperty
    a_sync_mult: assert property (p_sync_mult)
        else $error("High speed select changed synchronous period");

    property p_async_mult;
        @(posedge mclk) disable iff (!resetn)
        !sync_m |-> mult == (wide ? (hs ? 7'h04 : 7'h10)
                                  : (hs ? 7'h10 : 7'h40));
    endproperty
    a_async_mult: assert property (p_async_mult)
        else $error("Asynchronous multiplier wrong");

    property p_low_only;
        @(posedge mclk) disable iff (!resetn)
        !wide |-> div_n == {8'h00, divisor_low_q};
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("High byte used in 8-bit mode");

    property p_free_run;
        @(posedge mclk) disable iff (!resetn)
        !div_wr ##1 !div_wr |-> pre_q != $past(pre_q);
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("Baud timer stalled");

    property p_tick_single;
        @(posedge mclk) disable iff (!resetn)
        baud_tick |=> !baud_tick [*3];
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("Baud tick longer than one cycle");

    property p_read_idle;
        @(posedge mclk) disable iff (!resetn)
        bus_req.rd && bus_req.addr == `BDG_OFS_BAUD_CONTROL
        |=> rd_data[`BDG_BC_RX_IDLE] == $past(receiver_idle_flag);
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("Receiver idle flag not shown on read");

endmodule

`default_nettype wire

// file: bdg_serial_model.sv
// Stand-in for the serial engines that consume baud ticks
`timescale 1ns/1ps
`default_nettype none

module bdg_serial_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // From the baud generator
    input  wire logic baud_tick,
    // Bench control
    input  wire logic frame_start,
    // Status back to the baud generator
    output var  logic receiver_idle_flag,
    output var  logic tx_shift_empty
);
    logic [3:0] bits_q;
    logic [3:0] bits_d;

    always_comb begin
        bits_d = bits_q;
        if (frame_start && bits_q == 4'h0) begin
            bits_d = 4'ha;
        end else if (baud_tick && bits_q != 4'h0) begin
            bits_d = bits_q - 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bits_q <= 4'h0;
        end else begin
            bits_q <= bits_d;
        end
    end

    assign receiver_idle_flag = (bits_q == 4'h0);
    assign tx_shift_empty     = (bits_q == 4'h0);
endmodule

`default_nettype wire

// file: serial_baud_rate_generator_tb.sv
// Self-checking bench for the baud generator
`timescale 1ns/1ps
`default_nettype none
`include "bdg_consts.svh"

module serial_baud_rate_generator_tb;
    import bdg_pkg::*;
    logic         mclk;
    logic         resetn;
    logic         frame_start;
    logic         baud_tick;
    logic         idle;
    logic         txe;
    bdg_bus_req_s req;
    logic [7:0]   rd_data;
    bdg_cfg_s     cfg;
    logic [7:0]   mir [0:4];
    int           errors;
    int           checks;

    bdg_baud_gen dut_u (
        .mclk               (mclk),
        .resetn             (resetn),
        .bus_req            (req),
        .rd_data            (rd_data),
        .receiver_idle_flag (idle),
        .tx_shift_empty     (txe),
        .baud_tick          (baud_tick),
        .cfg                (cfg)
    );

    bdg_serial_model partner_u (
        .mclk               (mclk),
        .resetn             (resetn),
        .baud_tick          (baud_tick),
        .frame_start        (frame_start),
        .receiver_idle_flag (idle),
        .tx_shift_empty     (txe)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
        if (a < 3'h5) begin
            mir[a] = d;
        end
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
        #1 d = rd_data;
    endtask

    // Edges after the current one until baud_tick is seen high
    task automatic tick_wait(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (baud_tick !== 1'b1 && k < 5000);
    endtask

    function automatic logic [7:0] exp_rd(input int a);
        case (a)
            0: return (mir[0] & `BDG_BC_WR_MASK) | {1'b0, idle, 6'h00};
            4: return (mir[4] & `BDG_TX_WR_MASK) | {6'h00, txe, 1'b0};
            1, 2, 3: return mir[a];
            default: return 8'h00;
        endcase
    endfunction

    function automatic int period(input logic s, input logic w,
                                  input logic h, input logic [7:0] hi,
                                  input logic [7:0] lo);
        int n;
        int m;
        n = w ? {hi, lo} : lo;
        m = s ? 4 : (w ? (h ? 4 : 16) : (h ? 16 : 64));
        return m * (n + 1);
    endfunction

    initial begin
        #200000;
        errors++;
        stop_test();
    end

    initial begin
        int         i;
        int         k;
        int         p;
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] hi;
        logic [7:0] lo;
        logic       s;
        logic       w;
        logic       h;
        resetn = 1'b0;
        req = '0;
        frame_start = 1'b0;
        errors = 0;
        checks = 0;
        for (i = 0; i < 5; i++) mir[i] = 8'h00;
        void'($urandom(32'h67db9613));
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        #1 check(cfg, 5'h00);
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            check(d, exp_rd(i));
        end
        for (i = 0; i < 16; i++) begin
            a = 3'($urandom % 8);
            d = 8'($urandom);
            wr(a, d);
            rd(a, d);
            check(d, exp_rd(a));
        end
        wr(3'h1, 8'h80);
        // Every mode, with a stray high byte in 8-bit mode
        for (i = 0; i < 8; i++) begin
            {s, w, h} = i[2:0];
            wr(3'h4, {3'h0, s, 1'b0, h, 2'h0});
            wr(3'h0, {4'h0, w, 3'h0});
            hi = 8'($urandom % 2);
            lo = 8'($urandom % 8);
            wr(3'h3, hi);
            wr(3'h2, lo);
            p = period(s, w, h, hi, lo);
            tick_wait(k);
            check(k, p);
            tick_wait(k);
            check(k, p);
            check(cfg, {s, h, w, 1'b0, 1'b1});
        end
        // Mid-count divisor write restarts the period
        repeat (5) @(posedge mclk);
        wr(3'h2, 8'h02);
        tick_wait(k);
        check(k, period(1'b1, 1'b1, 1'b1, hi, 8'h02));
        @(posedge mclk);
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        rd(3'h0, d);
        check(d[6], 1'b0);
        check(d, exp_rd(0));
        stop_test();
    end
endmodule

`default_nettype wire
